// ### rtl/ovfl_cfg.svh
// Constants for the output voltage fault limit block
`ifndef OVFL_CFG_SVH
`define OVFL_CFG_SVH
// ==========================================
// Command codes
`define OVFL_CODE_OV_THR 8'h40
`define OVFL_CODE_OV_RESP 8'h41
`define OVFL_CODE_UV_THR 8'h44
// ==========================================
// Response byte layout and reset value
`define OVFL_OV_RESP_RST 8'h80
`define OVFL_BEH_DISABLE_BIT 7
`define OVFL_RETRY_MSB 5
`define OVFL_RETRY_LSB 3
`define OVFL_DELAY_MSB 2
`define OVFL_DELAY_LSB 0
`define OVFL_RETRY_NONE 3'h0
`define OVFL_RETRY_CONT 3'h7
// ==========================================
// Default threshold ratios to the strap setpoint
`define OVFL_OV_NUM 24'h00000B
`define OVFL_OV_DEN 24'h00000A
`define OVFL_UV_NUM 24'h000055
`define OVFL_UV_DEN 24'h000064
// ==========================================
// Setpoint per strap code, volts times 2^13
`define OVFL_SP0 16'h1333
`define OVFL_SP1 16'h1999
`define OVFL_SP2 16'h2000
`define OVFL_SP3 16'h2666
`define OVFL_SP4 16'h3000
`define OVFL_SP5 16'h3999
`define OVFL_SP6 16'h5000
`define OVFL_SP7 16'h6999
// ==========================================
// Timing
`define OVFL_CLK_HZ 40000000
`define OVFL_RETRY_UNIT_MS 35
`define OVFL_RETRY_UNIT_CYC (`OVFL_CLK_HZ / 1000 * `OVFL_RETRY_UNIT_MS)
`define OVFL_STRAP_LOAD_CNT 2'h2
`define OVFL_STRAP_DONE_CNT 2'h3
`endif

// ### rtl/ovfl_pkg.sv
// Types shared by the output voltage fault limit block
package ovfl_pkg;
  // ==========================================
  // Command request from the management bus engine
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] code;
    logic [7:0] page;
    logic [15:0] wdata;
  } ovfl_cmd_t;

  // ==========================================
  // One output voltage sample
  typedef struct packed {
    logic valid;
    logic [7:0] rail;
    logic [15:0] vout;
  } ovfl_meas_t;

  // ==========================================
  // Per-rail protection state
  typedef enum logic [1:0] {
    OVFL_ST_OFF = 2'b00,
    OVFL_ST_RUN = 2'b01,
    OVFL_ST_WAIT = 2'b10,
    OVFL_ST_LATCHED = 2'b11
  } ovfl_rail_st_t;
endpackage

// ### rtl/ovfl_retry_timer.sv
// Start-to-start restart interval timer for one rail
`include "ovfl_cfg.svh"
module ovfl_retry_timer #(
  parameter int unsigned UNIT_CYC = `OVFL_RETRY_UNIT_CYC
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // Control
  input wire logic i_start,
  input wire logic [2:0] i_delay,
  // Status
  output logic o_elapsed
);
  import ovfl_pkg::*;

  localparam int PRE_W = $clog2(UNIT_CYC + 1);

  logic [PRE_W-1:0] pre;
  logic [PRE_W-1:0] next_pre;
  logic [3:0] ticks;
  logic [3:0] next_ticks;
  logic next_elapsed;
  logic tick;

  // ==========================================
  // Unit divider and unit count, both restarted by an attempt start
  always_comb begin
    tick = (pre == PRE_W'(UNIT_CYC - 1));
    if (i_start || tick) begin
      next_pre = '0;
    end else begin
      next_pre = pre + PRE_W'(1);
    end
    if (i_start) begin
      next_ticks = 4'h0;
    end else if (tick && ticks != 4'hF) begin
      next_ticks = ticks + 4'h1;
    end else begin
      next_ticks = ticks;
    end
    // Interval is (delay + 1) units from the attempt start
    next_elapsed = !i_start && (next_ticks > {1'b0, i_delay}); // RL11 RL12
  end

  // Divider runs even when idle; cheaper than gating per rail
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      pre <= '0;
      ticks <= 4'h0;
      o_elapsed <= 1'b0;
    end else begin
      pre <= next_pre;
      ticks <= next_ticks;
      o_elapsed <= next_elapsed;
    end
  end
endmodule

// ### rtl/ovfl_top.sv
// Output over/under-voltage limits, response and restart sequencing
`include "ovfl_cfg.svh"

// What this block does
// (RL1) Over-voltage threshold at code 40h, two bytes, read and write.
// (RL2) Thresholds are unsigned 16-bit codes, volts equal code times 2^-13.
// (RL3) Over-voltage threshold defaults to 1.10 times the strap setpoint.
// (RL4) All three commands are held per rail, chosen by page.
// (RL5) Over-voltage response at code 41h, one byte, reset 80h.
// (RL6) Bits 7:6 behaviour; 10/11 disable and apply retry bits 5:3.
// (RL7) Over-voltage fault pulls alert low and sets its fault flag.
// (RL8) Fault flags clear only on the clear-faults command.
// (RL9) Retry 000 keeps the output off until device restart.
// (RL10) Retry 111 restarts until disabled, bias lost or another fault.
// (RL11) Retry interval is (delay field plus one) times 35 ms.
// (RL12) Interval runs from one attempt start to the next start.
// (RL13) Host should keep the response at no restarts.
// (RL14) Under-voltage threshold at code 44h, two bytes, read and write.
// (RL15) Under-voltage detection masked while ramping, before power good, or off.
// (RL16) Host keeps under-voltage threshold below the power-good threshold.
// (RL17) Under-voltage threshold defaults to 0.85 times the strap setpoint.
// (RL18) Each sample is compared against both thresholds of its rail; this block compares a sample only while its rail runs.
// (RL19) A restart re-enables through soft start and re-enters fault handling.
module ovfl_top #(
  parameter int unsigned N_RAILS = 2,
  parameter int unsigned RETRY_UNIT_CYC = `OVFL_RETRY_UNIT_CYC
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // Command port
  input wire ovfl_pkg::ovfl_cmd_t i_cmd,
  input wire logic i_clear_faults,
  output logic [15:0] o_cmd_rdata,
  output logic o_cmd_rvalid,
  output logic o_cmd_unknown,
  // Pins
  input wire logic [2:0] i_setpoint_strap,
  input wire logic [N_RAILS-1:0] i_rail_enable,
  output logic o_alert_line,
  output logic o_alert_line_oe_n,
  // Measurement and rail status
  input wire ovfl_pkg::ovfl_meas_t i_meas,
  input wire logic [N_RAILS-1:0] i_output_ok_flag,
  input wire logic [N_RAILS-1:0] i_ramping,
  input wire logic [N_RAILS-1:0] i_other_fault,
  // Rail control and fault flags
  output logic [N_RAILS-1:0] o_rail_run,
  output logic [N_RAILS-1:0] o_ov_fault,
  output logic [N_RAILS-1:0] o_uv_fault
);
  import ovfl_pkg::*;

  localparam int RAIL_W = (N_RAILS > 1) ? $clog2(N_RAILS) : 1;

  // ==========================================
  // Pin synchronisers and strap capture
  logic [2:0] strap_s1;
  logic [2:0] strap_s2;
  logic [N_RAILS-1:0] en_s1;
  logic [N_RAILS-1:0] en_s2;
  logic [1:0] load_cnt;
  logic [1:0] next_load_cnt;
  logic load_dflt;
  logic [15:0] sp_code;
  // Products are 24 bits wide: the top setpoint times 85 does not fit in 20
  logic [23:0] ov_prod;
  logic [23:0] uv_prod;
  logic [15:0] ov_dflt;
  logic [15:0] uv_dflt;

  // Strap is sampled after release, once the sync chain holds pin data
  always_comb begin
    load_dflt = (load_cnt == `OVFL_STRAP_LOAD_CNT);
    if (load_cnt != `OVFL_STRAP_DONE_CNT) begin
      next_load_cnt = load_cnt + 2'h1;
    end else begin
      next_load_cnt = load_cnt;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      strap_s1 <= 3'h0;
      strap_s2 <= 3'h0;
      en_s1 <= '0;
      en_s2 <= '0;
      load_cnt <= 2'h0;
    end else begin
      strap_s1 <= i_setpoint_strap;
      strap_s2 <= strap_s1;
      en_s1 <= i_rail_enable;
      en_s2 <= en_s1;
      load_cnt <= next_load_cnt;
    end
  end

  // Setpoint lookup and default thresholds
  always_comb begin
    case (strap_s2)
      3'h0: sp_code = `OVFL_SP0;
      3'h1: sp_code = `OVFL_SP1;
      3'h2: sp_code = `OVFL_SP2;
      3'h3: sp_code = `OVFL_SP3;
      3'h4: sp_code = `OVFL_SP4;
      3'h5: sp_code = `OVFL_SP5;
      3'h6: sp_code = `OVFL_SP6;
      default: sp_code = `OVFL_SP7;
    endcase
    // Integer truncation of the scaled setpoint; the quotient always fits 16 bits
    ov_prod = {8'h00, sp_code} * `OVFL_OV_NUM / `OVFL_OV_DEN; // RL3 RL2
    uv_prod = {8'h00, sp_code} * `OVFL_UV_NUM / `OVFL_UV_DEN; // RL17
    ov_dflt = ov_prod[15:0];
    uv_dflt = uv_prod[15:0];
  end

  // ==========================================
  // Per-rail registers, protection state and flags
  logic [15:0] ov_thr [N_RAILS];
  logic [15:0] uv_thr [N_RAILS];
  logic [7:0] ov_resp [N_RAILS];

  genvar g;
  generate
    for (g = 0; g < N_RAILS; g++) begin : g_rail
      logic wr_hit;
      logic [15:0] next_ov_thr;
      logic [15:0] next_uv_thr;
      logic [7:0] next_ov_resp;
      ovfl_rail_st_t st;
      ovfl_rail_st_t next_st;
      logic next_run;
      logic next_ov_flag;
      logic next_uv_flag;
      logic meas_hit;
      logic ov_det;
      logic uv_det;
      logic start;
      logic elapsed;
      logic retry_cont;

      // Command writes, page selects the rail
      always_comb begin
        wr_hit = i_cmd.wr && (i_cmd.page == 8'(g)); // RL4
        next_ov_thr = ov_thr[g];
        next_uv_thr = uv_thr[g];
        next_ov_resp = ov_resp[g];
        if (load_dflt) begin
          next_ov_thr = ov_dflt; // RL3
          next_uv_thr = uv_dflt; // RL17
        end else if (wr_hit) begin
          if (i_cmd.code == `OVFL_CODE_OV_THR) begin
            next_ov_thr = i_cmd.wdata; // RL1
          end else if (i_cmd.code == `OVFL_CODE_OV_RESP) begin
            next_ov_resp = i_cmd.wdata[7:0]; // RL5
          end else if (i_cmd.code == `OVFL_CODE_UV_THR) begin
            next_uv_thr = i_cmd.wdata; // RL14
          end
        end
      end

      always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
          ov_thr[g] <= 16'h0000;
          uv_thr[g] <= 16'h0000;
          ov_resp[g] <= `OVFL_OV_RESP_RST; // RL5
        end else begin
          ov_thr[g] <= next_ov_thr;
          uv_thr[g] <= next_uv_thr;
          ov_resp[g] <= next_ov_resp;
        end
      end

      // Fault detection and restart sequencing
      always_comb begin
        meas_hit = i_meas.valid && (i_meas.rail == 8'(g));
        // Faults only counted while the rail is actually driven
        ov_det = meas_hit && (st == OVFL_ST_RUN) && (i_meas.vout > ov_thr[g]); // RL18
        uv_det = meas_hit && (st == OVFL_ST_RUN) && i_output_ok_flag[g]
          && !i_ramping[g] && (i_meas.vout < uv_thr[g]); // RL15 RL18
        // Unused behaviour and retry codes fall back to a latched shutdown
        retry_cont = ov_resp[g][`OVFL_BEH_DISABLE_BIT]
          && (ov_resp[g][`OVFL_RETRY_MSB:`OVFL_RETRY_LSB] == `OVFL_RETRY_CONT); // RL6
        next_st = st;
        start = 1'b0;
        case (st)
          OVFL_ST_OFF: begin
            if (en_s2[g] && !i_other_fault[g]) begin
              next_st = OVFL_ST_RUN;
              start = 1'b1;
            end
          end
          OVFL_ST_RUN: begin
            if (!en_s2[g]) begin
              next_st = OVFL_ST_OFF;
            end else if (i_other_fault[g]) begin
              next_st = OVFL_ST_LATCHED;
            end else if (ov_det && retry_cont) begin
              next_st = OVFL_ST_WAIT; // RL10
            end else if (ov_det) begin
              next_st = OVFL_ST_LATCHED; // RL9
            end
          end
          OVFL_ST_WAIT: begin
            if (!en_s2[g]) begin
              next_st = OVFL_ST_OFF; // RL10
            end else if (i_other_fault[g]) begin
              next_st = OVFL_ST_LATCHED; // RL10
            end else if (elapsed) begin
              next_st = OVFL_ST_RUN; // RL19 RL12
              start = 1'b1;
            end
          end
          default: begin
            next_st = OVFL_ST_LATCHED; // RL9
          end
        endcase
        next_run = (next_st == OVFL_ST_RUN); // RL19
        // Set wins over a clear in the same cycle
        next_ov_flag = ov_det || (o_ov_fault[g] && !i_clear_faults); // RL7 RL8
        next_uv_flag = uv_det || (o_uv_fault[g] && !i_clear_faults); // RL8
      end

      always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
          st <= OVFL_ST_OFF;
          o_rail_run[g] <= 1'b0;
          o_ov_fault[g] <= 1'b0;
          o_uv_fault[g] <= 1'b0;
        end else begin
          st <= next_st;
          o_rail_run[g] <= next_run;
          o_ov_fault[g] <= next_ov_flag;
          o_uv_fault[g] <= next_uv_flag;
        end
      end

      ovfl_retry_timer #(
        .UNIT_CYC(RETRY_UNIT_CYC)
      ) u_timer (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_start(start),
        .i_delay(ov_resp[g][`OVFL_DELAY_MSB:`OVFL_DELAY_LSB]),
        .o_elapsed(elapsed)
      );
    end
  endgenerate

  // ==========================================
  // Command reads and alert pin
  logic [15:0] next_rdata;
  logic next_unknown;
  logic next_alert_oe_n;
  logic [RAIL_W-1:0] rd_idx;
  logic page_ok;

  always_comb begin
    rd_idx = i_cmd.page[RAIL_W-1:0];
    page_ok = ({24'h000000, i_cmd.page} < 32'(N_RAILS)); // RL4
    next_rdata = 16'h0000;
    next_unknown = 1'b0;
    if (!page_ok) begin
      next_unknown = 1'b1;
    end else if (i_cmd.code == `OVFL_CODE_OV_THR) begin
      next_rdata = ov_thr[rd_idx]; // RL1
    end else if (i_cmd.code == `OVFL_CODE_OV_RESP) begin
      next_rdata = {8'h00, ov_resp[rd_idx]}; // RL5
    end else if (i_cmd.code == `OVFL_CODE_UV_THR) begin
      next_rdata = uv_thr[rd_idx]; // RL14
    end else begin
      next_unknown = 1'b1;
    end
    // Alert stays low while any flag is held
    next_alert_oe_n = !(|{o_ov_fault, o_uv_fault}); // RL7
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_cmd_rdata <= 16'h0000;
      o_cmd_rvalid <= 1'b0;
      o_cmd_unknown <= 1'b0;
      o_alert_line_oe_n <= 1'b1;
    end else begin
      if (i_cmd.rd) begin
        o_cmd_rdata <= next_rdata;
      end
      o_cmd_rvalid <= i_cmd.rd;
      o_cmd_unknown <= i_cmd.rd && next_unknown;
      o_alert_line_oe_n <= next_alert_oe_n;
    end
  end

  // Open-drain alert only ever drives low
  // The pull-up outside the device supplies the released level
  assign o_alert_line = 1'b0;
endmodule

// ### tb/ovfl_host.sv
// Management bus host controller model driving the command port
module ovfl_host
  import ovfl_pkg::*;
(
  // Clock
  input wire logic i_mclk,
  // Command side
  output ovfl_pkg::ovfl_cmd_t o_cmd,
  output logic o_clear_faults,
  input wire logic [15:0] i_rdata,
  input wire logic i_rvalid,
  input wire logic i_unknown
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle at time zero
  initial begin
    o_cmd = '0;
    o_clear_faults = 1'b0;
  end
  // Release scrambles data fields so stale values are never trusted
  task automatic drop();
    @(negedge i_mclk);
    o_cmd.wr = 1'b0;
    o_cmd.rd = 1'b0;
    o_clear_faults = 1'b0;
    o_cmd.wdata = ~o_cmd.wdata;
    o_cmd.page = ~o_cmd.page;
  endtask
  // One write or read request, held for one edge
  task automatic put(input logic w, input logic [7:0] c, input logic [7:0] p,
                     input logic [15:0] d);
    @(negedge i_mclk);
    o_cmd = '{wr: w, rd: !w, code: c, page: p, wdata: d};
    drop();
  endtask
  // Answer is settled by the falling edge after the taking edge
  task automatic read(input logic [7:0] c, input logic [7:0] p,
                      output logic [15:0] d, output logic u);
    put(1'b0, c, p, 16'h0000);
    d = i_rvalid ? i_rdata : 16'hXXXX;
    u = i_rvalid ? i_unknown : 1'bx;
  endtask
  // Clear-faults pulse
  task automatic clear();
    @(negedge i_mclk);
    o_clear_faults = 1'b1;
    drop();
  endtask
endmodule

// ### tb/ovfl_top_sva.sv
// Checker for the output voltage fault limit block, bound to its top module
`include "ovfl_cfg.svh"
module ovfl_top_sva
  import ovfl_pkg::*;
#(
  parameter int unsigned N_RAILS = 2,
  parameter int unsigned RETRY_UNIT_CYC = `OVFL_RETRY_UNIT_CYC
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // Command port
  input wire ovfl_pkg::ovfl_cmd_t i_cmd,
  input wire logic i_clear_faults,
  input wire logic [15:0] o_cmd_rdata,
  input wire logic o_cmd_rvalid,
  input wire logic o_cmd_unknown,
  // Pins
  input wire logic [2:0] i_setpoint_strap,
  input wire logic [N_RAILS-1:0] i_rail_enable,
  input wire logic o_alert_line,
  input wire logic o_alert_line_oe_n,
  // Measurement and rail status
  input wire ovfl_pkg::ovfl_meas_t i_meas,
  input wire logic [N_RAILS-1:0] i_output_ok_flag,
  input wire logic [N_RAILS-1:0] i_ramping,
  input wire logic [N_RAILS-1:0] i_other_fault,
  // Rail control and fault flags
  input wire logic [N_RAILS-1:0] o_rail_run,
  input wire logic [N_RAILS-1:0] o_ov_fault,
  input wire logic [N_RAILS-1:0] o_uv_fault
);
  // ==========================================
  // Shadow of the rail 0 response byte
  logic [7:0] resp0;
  logic [7:0] next_resp0;
  // Follows host writes only, so a design that drops writes is caught
  always_comb begin
    next_resp0 = resp0;
    if (i_cmd.wr && i_cmd.code == `OVFL_CODE_OV_RESP && i_cmd.page == 8'h00) begin
      next_resp0 = i_cmd.wdata[7:0];
    end
  end
  // Register the shadow
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      resp0 <= `OVFL_OV_RESP_RST;
    end else begin
      resp0 <= next_resp0;
    end
  end
  // ==========================================
  // Properties
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rstn);
  sequence s_ov_hit;
    i_meas.valid && i_meas.rail == 8'h00 ##1 $rose(o_ov_fault[0]);
  endsequence
  property p_rd_answer;
    i_cmd.rd |=> o_cmd_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_resp_read;
    i_cmd.rd && i_cmd.code == `OVFL_CODE_OV_RESP && i_cmd.page == 8'h00
      |=> o_cmd_rdata == {8'h00, $past(resp0)};
  endproperty
  a_resp_read: assert property (p_resp_read) else $error("response readback");
  property p_unknown;
    o_cmd_unknown |-> o_cmd_rvalid && o_cmd_rdata == 16'h0000;
  endproperty
  a_unknown: assert property (p_unknown) else $error("unknown read data");
  property p_ov_stop;
    s_ov_hit |-> !o_rail_run[0];
  endproperty
  a_ov_stop: assert property (p_ov_stop) else $error("rail kept running");
  property p_ov_alert;
    s_ov_hit |=> !o_alert_line_oe_n && o_alert_line == 1'b0;
  endproperty
  a_ov_alert: assert property (p_ov_alert) else $error("alert not driven");
  property p_sticky;
    o_ov_fault[0] && !i_clear_faults |=> o_ov_fault[0];
  endproperty
  a_sticky: assert property (p_sticky) else $error("fault flag dropped");
  property p_clear;
    i_clear_faults && !i_meas.valid |=> o_ov_fault == '0 && o_uv_fault == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("flags not cleared");
  property p_uv_cause;
    $rose(o_uv_fault[1]) |-> $past(i_meas.valid) && $past(i_output_ok_flag[1])
      && !$past(i_ramping[1]);
  endproperty
  a_uv_cause: assert property (p_uv_cause) else $error("masked undervoltage");
  property p_no_retry;
    s_ov_hit ##0 (resp0[5:3] == `OVFL_RETRY_NONE) |-> !o_rail_run[0] [*8];
  endproperty
  a_no_retry: assert property (p_no_retry) else $error("latched rail restarted");
endmodule

bind ovfl_top ovfl_top_sva #(.N_RAILS(N_RAILS), .RETRY_UNIT_CYC(RETRY_UNIT_CYC)) i_ovfl_top_sva (.*);

// ### tb/testbench.sv
// Self-checking testbench for the output voltage fault limit block
`include "ovfl_cfg.svh"
module testbench;
  import ovfl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // Short retry unit keeps the run brief
  localparam int unsigned UNIT = 20;
  localparam logic [15:0] OV_DEF = 16'((int'(`OVFL_SP3) * 11) / 10);
  localparam logic [15:0] UV_DEF = 16'((int'(`OVFL_SP3) * 85) / 100);
  // Defaults for the highest strap code, used after the mid-run reset
  localparam logic [15:0] OV_DEF7 = 16'((int'(`OVFL_SP7) * 11) / 10);
  localparam logic [15:0] UV_DEF7 = 16'((int'(`OVFL_SP7) * 85) / 100);
  logic mclk, rstn, clr, rvalid, unk, alert, oe_n, gu;
  logic [15:0] rdata, got;
  logic [2:0] strap;
  logic [1:0] en, ok, ramp, oth, run, ovf, uvf;
  ovfl_cmd_t cmd;
  ovfl_meas_t meas;
  int fail_count, checks_done, cyc, t1, t2;
  // ==========================================
  // Design and host model
  ovfl_top #(.N_RAILS(2), .RETRY_UNIT_CYC(UNIT)) i_ovfl_top (.i_mclk(mclk), .i_rstn(rstn),
    .i_cmd(cmd), .i_clear_faults(clr), .o_cmd_rdata(rdata), .o_cmd_rvalid(rvalid),
    .o_cmd_unknown(unk), .i_setpoint_strap(strap), .i_rail_enable(en), .o_alert_line(alert),
    .o_alert_line_oe_n(oe_n), .i_meas(meas), .i_output_ok_flag(ok), .i_ramping(ramp),
    .i_other_fault(oth), .o_rail_run(run), .o_ov_fault(ovf), .o_uv_fault(uvf));
  ovfl_host i_ovfl_host (.i_mclk(mclk), .o_cmd(cmd), .o_clear_faults(clr), .i_rdata(rdata),
    .i_rvalid(rvalid), .i_unknown(unk));
  // ==========================================
  // Helpers
  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string s);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, s, g, e);
    end
  endtask
  task automatic chkb(input logic g, input logic e, input string s);
    chk({15'h0000, g}, {15'h0000, e}, s);
  endtask
  task automatic rd_chk(input logic [7:0] c, input logic [7:0] p, input logic [15:0] e,
                        input logic u);
    i_ovfl_host.read(c, p, got, gu);
    chk(got, e, "read data");
    chkb(gu, u, "unknown flag");
  endtask
  // One-cycle sample; the value is scrambled once the pulse is gone
  task automatic sample(input logic [7:0] r, input logic [15:0] v);
    @(negedge mclk);
    meas = '{valid: 1'b1, rail: r, vout: v};
    @(negedge mclk);
    meas.valid = 1'b0;
    meas.vout = ~v;
  endtask
  task automatic wait_run(input int r, output int t);
    for (int k = 0; k < 3000 && run[r] !== 1'b1; k++) @(negedge mclk);
    t = cyc;
    chkb(run[r], 1'b1, "rail start");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_defaults();
    for (int p = 0; p < 2; p++) begin
      rd_chk(`OVFL_CODE_OV_THR, p[7:0], OV_DEF, 1'b0);
      rd_chk(`OVFL_CODE_UV_THR, p[7:0], UV_DEF, 1'b0);
      rd_chk(`OVFL_CODE_OV_RESP, p[7:0], 16'h0080, 1'b0);
    end
  endtask
  task automatic t_regs();
    i_ovfl_host.put(1'b1, `OVFL_CODE_OV_THR, 8'h00, 16'hFFFF);
    i_ovfl_host.put(1'b1, `OVFL_CODE_UV_THR, 8'h01, 16'h0001);
    i_ovfl_host.put(1'b1, `OVFL_CODE_OV_RESP, 8'h01, 16'hABC7);
    rd_chk(`OVFL_CODE_OV_THR, 8'h00, 16'hFFFF, 1'b0);
    rd_chk(`OVFL_CODE_UV_THR, 8'h01, 16'h0001, 1'b0);
    rd_chk(`OVFL_CODE_OV_RESP, 8'h01, 16'h00C7, 1'b0);
    rd_chk(`OVFL_CODE_UV_THR, 8'h00, UV_DEF, 1'b0);
    rd_chk(`OVFL_CODE_OV_THR, 8'h01, OV_DEF, 1'b0);
    rd_chk(8'h42, 8'h00, 16'h0000, 1'b1);
    rd_chk(`OVFL_CODE_OV_THR, 8'h02, 16'h0000, 1'b1);
  endtask
  task automatic t_latched();
    // Host leaves rail 0 at the no-restart response
    rd_chk(`OVFL_CODE_OV_RESP, 8'h00, 16'h0080, 1'b0);
    i_ovfl_host.put(1'b1, `OVFL_CODE_OV_THR, 8'h00, 16'h1000);
    en[0] = 1'b1;
    wait_run(0, t1);
    // Output-ok stays low so only the over-voltage flag can pull alert
    sample(8'h00, 16'h1000);
    chkb(ovf[0], 1'b0, "equal to limit");
    sample(8'h00, 16'h1001);
    chkb(ovf[0], 1'b1, "over limit");
    chkb(run[0], 1'b0, "shutdown");
    @(negedge mclk);
    chkb(oe_n, 1'b0, "alert");
    chkb(alert, 1'b0, "alert level");
    en[0] = 1'b0;
    repeat (8) @(negedge mclk);
    en[0] = 1'b1;
    repeat (100) @(negedge mclk);
    chkb(run[0], 1'b0, "latched");
    chkb(ovf[0], 1'b1, "flag held");
    i_ovfl_host.clear();
    chkb(ovf[0], 1'b0, "flag cleared");
    @(negedge mclk);
    chkb(oe_n, 1'b1, "alert released");
  endtask
  task automatic t_uv();
    i_ovfl_host.put(1'b1, `OVFL_CODE_UV_THR, 8'h01, 16'h2000);
    en[1] = 1'b1;
    wait_run(1, t1);
    sample(8'h01, 16'h1000);
    chkb(uvf[1], 1'b0, "before output ok");
    ok[1] = 1'b1;
    ramp[1] = 1'b1;
    sample(8'h01, 16'h1000);
    chkb(uvf[1], 1'b0, "while ramping");
    ramp[1] = 1'b0;
    sample(8'h01, 16'h2000);
    chkb(uvf[1], 1'b0, "equal to limit");
    sample(8'h01, 16'h1FFF);
    chkb(uvf[1], 1'b1, "under limit");
    i_ovfl_host.clear();
    chkb(uvf[1], 1'b0, "flag cleared");
  endtask
  task automatic t_retry();
    for (int d = 0; d < 8; d++) begin
      i_ovfl_host.put(1'b1, `OVFL_CODE_OV_RESP, 8'h01, {11'h01F, d[2:0], 2'h0} >> 2);
      sample(8'h01, 16'hFFFF);
      chkb(run[1], 1'b0, "retry shutdown");
      wait_run(1, t1);
      repeat (5) @(negedge mclk);
      sample(8'h01, 16'hFFFF);
      wait_run(1, t2);
      t2 = t2 - t1;
      chk(16'((t2 - (d + 1) * UNIT + 2) <= 4 ? (d + 1) * UNIT : t2), 16'((d + 1) * UNIT),
          "start to start");
    end
    oth[1] = 1'b1;
    repeat (200) @(negedge mclk);
    chkb(run[1], 1'b0, "other fault stop");
  endtask
  // Mid-run reset with a new strap: latch released, defaults reloaded
  task automatic t_restart();
    @(negedge mclk);
    rstn = 1'b0;
    strap = 3'h7;
    repeat (4) @(negedge mclk);
    chkb(oe_n, 1'b1, "alert in reset");
    chk({14'h0000, ovf}, 16'h0000, "flags in reset");
    rstn = 1'b1;
    repeat (6) @(negedge mclk);
    rd_chk(`OVFL_CODE_OV_THR, 8'h00, OV_DEF7, 1'b0);
    rd_chk(`OVFL_CODE_UV_THR, 8'h01, UV_DEF7, 1'b0);
    rd_chk(`OVFL_CODE_OV_RESP, 8'h01, 16'h0080, 1'b0);
    wait_run(0, t1);
  endtask
  // ==========================================
  // Clock, cycle count, main sequence and watchdog
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) cyc++;
  initial begin
    {rstn, en, ok, ramp, oth, meas} = '0;
    strap = 3'h3;
    repeat (4) @(negedge mclk);
    rstn = 1'b1;
    repeat (6) @(negedge mclk);
    t_defaults();
    t_regs();
    t_latched();
    t_uv();
    t_retry();
    t_restart();
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    $display("wrong value at %0t: run did not end", $time);
    finish_test();
  end
endmodule
